// ==== design/iso_rx_defs.vh ====
`ifndef ISO_RX_DEFS_VH
`define ISO_RX_DEFS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ISO_RX_CTRL_SET 12'h400
`define ISO_RX_CTRL_CLR 12'h404
`define ISO_RX_PTR 12'h40C
`define ISO_RX_CTX_STRIDE 12'h020
`define ISO_RX_IRQ_STATUS 12'h500
`define ISO_RX_IRQ_CLEAR 12'h504
`define ISO_RX_IRQ_ENABLE 12'h508
// ----------------------------------------
// Control word bit positions
// ----------------------------------------
`define BIT_BUFFER_FILL 31
`define BIT_RUN 15
`define BIT_WAKE 12
`define BIT_DEAD 11
`define BIT_ACTIVE 10
`define BIT_BETA 9
`define BIT_RSVD8 8
`define SPD_MSB 7
`define SPD_LSB 5
`define EVT_MSB 4
`define EVT_LSB 0
// ----------------------------------------
// Speed codes
// ----------------------------------------
`define SPD_100 3'h0
`define SPD_200 3'h1
`define SPD_400 3'h2
`define SPD_800 3'h3
// ----------------------------------------
// Event codes
// ----------------------------------------
`define EVT_NONE 5'h00
`define EVT_ACK_COMPLETE 5'h11
`define EVT_ACK_DATA_ERROR 5'h1D
`define EVT_LONG_PACKET 5'h02
`define EVT_OVERRUN 5'h05
`define EVT_DESCRIPTOR_READ 5'h06
`define EVT_DATA_WRITE 5'h07
`define EVT_UNKNOWN 5'h0E
// ----------------------------------------
// Packet status from the receive path
// ----------------------------------------
`define PKT_OK 3'h0
`define PKT_CRC_ERR 3'h1
`define PKT_LEN_ERR 3'h2
`define PKT_OVERRUN 3'h3
`define PKT_LONG 3'h4
`endif

// ==== design/iso_rx_ptr_mem.v ====
`timescale 1ns/10ps
module iso_rx_ptr_mem #(
  parameter AW = 2,
  parameter DW = 32
) (
  // Clock
  input wire ref_clk,
  // Write port from descriptor engine
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  // Read ports
  input wire [AW-1:0] rd_addr_a,
  output reg [DW-1:0] rd_data_a,
  input wire [AW-1:0] rd_addr_b,
  output reg [DW-1:0] rd_data_b
);
  // Contents undefined after reset by design, so no reset on the array
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_a <= mem[rd_addr_a];
    rd_data_b <= mem[rd_addr_b];
  end
endmodule

// ==== design/iso_rx_ctx.v ====
`timescale 1ns/10ps
`include "iso_rx_defs.vh"
module iso_rx_ctx (
  // Clock and reset
  input wire ref_clk,
  input wire arst_n,
  // Software strobes
  input wire set_stb,
  input wire clr_stb,
  input wire [31:0] wr_bits,
  // Receive path
  input wire pkt_done,
  input wire pkt_beta,
  input wire [2:0] pkt_speed,
  input wire [2:0] pkt_status,
  // Descriptor engine
  input wire desc_fetch,
  input wire dma_read_err,
  input wire dma_write_err,
  input wire unknown_err,
  input wire list_end,
  // State out
  output wire [31:0] ctrl_word,
  output reg active,
  output reg start_req,
  output reg backout,
  output reg pkt_evt,
  output reg dead_evt,
  output reg resp_beta
);
  reg run;
  reg wake;
  reg dead;
  reg beta_format_received;
  reg buffer_fill_mode;
  reg [2:0] spd;
  reg [4:0] evt;
  wire set_run = set_stb & wr_bits[`BIT_RUN];
  wire clr_run = clr_stb & wr_bits[`BIT_RUN];
  wire next_run = (run | set_run) & ~clr_run;
  wire fatal = run & (dma_read_err | dma_write_err | unknown_err);
  wire start = next_run & ~run;
  wire resume = run & ~dead & ~active & set_stb & wr_bits[`BIT_WAKE];
  wire pkt_take = pkt_done & active & ~fatal;
  wire pkt_bad = (pkt_status != `PKT_OK);

  assign ctrl_word = {buffer_fill_mode, 15'h0000, run, 2'b00, wake, dead, active,
                      beta_format_received, 1'b0, spd, evt};

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      run <= 1'b0;
      wake <= 1'b0;
      dead <= 1'b0;
      active <= 1'b0;
      beta_format_received <= 1'b0;
      buffer_fill_mode <= 1'b0;
      spd <= `SPD_100;
      evt <= `EVT_NONE;
      start_req <= 1'b0;
      backout <= 1'b0;
      pkt_evt <= 1'b0;
      dead_evt <= 1'b0;
      resp_beta <= 1'b0;
    end else begin
      run <= next_run;
      // Mode may only change while stopped, a change mid-stream would corrupt buffers
      if (~run & ~active) begin
        if (set_stb & wr_bits[`BIT_BUFFER_FILL]) begin
          buffer_fill_mode <= 1'b1;
        end else if (clr_stb & wr_bits[`BIT_BUFFER_FILL]) begin
          buffer_fill_mode <= 1'b0;
        end
      end
      // Set wins over the fetch clear
      if (set_stb & wr_bits[`BIT_WAKE]) begin
        wake <= 1'b1;
      end else if (desc_fetch) begin
        wake <= 1'b0;
      end
      if (fatal) begin
        dead <= 1'b1;
      end else if (run & clr_run) begin
        dead <= 1'b0;
      end
      dead_evt <= fatal & ~dead;
      if (fatal | ~next_run) begin
        active <= 1'b0;
      end else if (start | resume) begin
        active <= 1'b1;
      end else if (list_end) begin
        active <= 1'b0;
      end
      start_req <= (start | resume) & ~fatal;
      backout <= pkt_take & buffer_fill_mode & pkt_bad;
      pkt_evt <= pkt_take & ~(buffer_fill_mode & pkt_bad);
      if (fatal) begin
        if (dma_read_err) begin
          evt <= `EVT_DESCRIPTOR_READ;
        end else if (dma_write_err) begin
          evt <= `EVT_DATA_WRITE;
        end else begin
          evt <= `EVT_UNKNOWN;
        end
      end else if (pkt_take) begin
        beta_format_received <= pkt_beta;
        resp_beta <= pkt_beta;
        spd <= pkt_speed;
        if (buffer_fill_mode) begin
          if (!pkt_bad) begin
            evt <= `EVT_ACK_COMPLETE;
          end
        end else if (pkt_status == `PKT_OK) begin
          evt <= `EVT_ACK_COMPLETE;
        end else if (pkt_status == `PKT_LONG) begin
          evt <= `EVT_LONG_PACKET;
        end else if (pkt_status == `PKT_OVERRUN) begin
          evt <= `EVT_OVERRUN;
        end else begin
          evt <= `EVT_ACK_DATA_ERROR;
        end
      end
    end
  end
endmodule

// ==== design/iso_receive_context_status.v ====
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "iso_rx_defs.vh"
module iso_receive_context_status #(
  parameter NCTX = 4
) (
  // Clock and reset
  input wire ref_clk,
  input wire arst_n,
  // Avalon-MM slave
  input wire [11:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Interrupt
  output reg irq,
  // Receive path, one lane per context
  input wire [NCTX-1:0] pkt_done,
  input wire [NCTX-1:0] pkt_beta,
  input wire [3*NCTX-1:0] pkt_speed,
  input wire [3*NCTX-1:0] pkt_status,
  // Descriptor engine
  input wire [NCTX-1:0] desc_fetch,
  input wire [NCTX-1:0] dma_read_err,
  input wire [NCTX-1:0] dma_write_err,
  input wire [NCTX-1:0] unknown_err,
  input wire [NCTX-1:0] list_end,
  input wire ptr_load,
  input wire [1:0] ptr_ctx,
  input wire [31:0] ptr_value,
  // Engine requests and status
  output reg fetch_start,
  output reg [1:0] fetch_ctx,
  output reg [31:0] fetch_addr,
  output reg [NCTX-1:0] ctx_busy,
  output reg [NCTX-1:0] backout,
  output reg [NCTX-1:0] resp_beta
);
  // ----------------------------------------
  // Bus slave state
  // ----------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_ANS = 3'b100;
  reg [2:0] state;
  wire [1:0] ctx_sel = avs_address[6:5];
  wire in_ctx_space = (avs_address[11:7] == 5'h08);
  wire [11:0] ctx_off = {7'h00, avs_address[4:0]};
  wire wr_take = (state == ST_ANS) & avs_write;
  wire [31:0] wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] wbits = avs_writedata & wmask;

  // ----------------------------------------
  // Per-context state
  // ----------------------------------------
  wire [32*NCTX-1:0] ctrl_words;
  wire [NCTX-1:0] act_w;
  wire [NCTX-1:0] start_w;
  wire [NCTX-1:0] backout_w;
  wire [NCTX-1:0] pkt_evt_w;
  wire [NCTX-1:0] dead_evt_w;
  wire [NCTX-1:0] beta_w;
  wire [31:0] ptr_rd_a;
  wire [31:0] ptr_rd_b;
  reg [1:0] issue_ctx;
  reg [1:0] issue_ctx2;
  reg issue;
  reg issue2;
  reg [NCTX-1:0] pending;
  reg [2*NCTX-1:0] irq_status;
  reg [2*NCTX-1:0] irq_enable;
  reg [31:0] next_rdata;
  reg [1:0] pick;
  reg pick_valid;
  integer k;

  genvar g;
  generate
    for (g = 0; g < NCTX; g = g + 1) begin : ctx
      wire sel = wr_take & in_ctx_space & (ctx_sel == g);
      iso_rx_ctx u_ctx (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .set_stb(sel & (ctx_off == (`ISO_RX_CTRL_SET - 12'h400))),
        .clr_stb(sel & (ctx_off == (`ISO_RX_CTRL_CLR - 12'h400))),
        .wr_bits(wbits),
        .pkt_done(pkt_done[g]),
        .pkt_beta(pkt_beta[g]),
        .pkt_speed(pkt_speed[3*g+2:3*g]),
        .pkt_status(pkt_status[3*g+2:3*g]),
        .desc_fetch(desc_fetch[g]),
        .dma_read_err(dma_read_err[g]),
        .dma_write_err(dma_write_err[g]),
        .unknown_err(unknown_err[g]),
        .list_end(list_end[g]),
        .ctrl_word(ctrl_words[32*g+31:32*g]),
        .active(act_w[g]),
        .start_req(start_w[g]),
        .backout(backout_w[g]),
        .pkt_evt(pkt_evt_w[g]),
        .dead_evt(dead_evt_w[g]),
        .resp_beta(beta_w[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Command pointer store
  // ----------------------------------------
  // Software has no write path here, only the descriptor engine loads it
  iso_rx_ptr_mem #(
    .AW(2),
    .DW(32)
  ) u_ptr (
    .ref_clk(ref_clk),
    .wr_en(ptr_load),
    .wr_addr(ptr_ctx),
    .wr_data(ptr_value),
    .rd_addr_a(ctx_sel),
    .rd_data_a(ptr_rd_a),
    .rd_addr_b(issue_ctx),
    .rd_data_b(ptr_rd_b)
  );

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @* begin
    next_rdata = 32'h0000_0000;
    if (in_ctx_space & ((ctx_off == 12'h000) | (ctx_off == 12'h004))) begin
      next_rdata = ctrl_words[32*ctx_sel +: 32];
    end else if (in_ctx_space & (ctx_off == (`ISO_RX_PTR - 12'h400))) begin
      next_rdata = ptr_rd_a;
    end else if (avs_address == `ISO_RX_IRQ_STATUS) begin
      next_rdata = {24'h00_0000, irq_status};
    end else if (avs_address == `ISO_RX_IRQ_ENABLE) begin
      next_rdata = {24'h00_0000, irq_enable};
    end
  end

  always @* begin
    pick = 2'b00;
    pick_valid = 1'b0;
    for (k = NCTX - 1; k >= 0; k = k - 1) begin
      if (pending[k]) begin
        pick = k[1:0];
        pick_valid = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Bus, fetch issue and interrupts
  // ----------------------------------------
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      irq <= 1'b0;
      irq_status <= 8'h00;
      irq_enable <= 8'h00;
      pending <= 4'h0;
      issue <= 1'b0;
      issue2 <= 1'b0;
      issue_ctx <= 2'b00;
      issue_ctx2 <= 2'b00;
      fetch_start <= 1'b0;
      fetch_ctx <= 2'b00;
      fetch_addr <= 32'h0000_0000;
      ctx_busy <= 4'h0;
      backout <= 4'h0;
      resp_beta <= 4'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          avs_waitrequest <= 1'b1;
          if (avs_read | avs_write) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Extra cycle lets the pointer store present registered data
          avs_readdata <= next_rdata;
          avs_waitrequest <= 1'b0;
          state <= ST_ANS;
        end
        ST_ANS: begin
          avs_waitrequest <= 1'b1;
          state <= ST_IDLE;
        end
        default: begin
          avs_waitrequest <= 1'b1;
          state <= ST_IDLE;
        end
      endcase
      if (wr_take & (avs_address == `ISO_RX_IRQ_ENABLE)) begin
        irq_enable <= wbits[7:0];
      end
      // Set wins over a clear in the same cycle
      irq_status <= (irq_status & ~((wr_take & (avs_address == `ISO_RX_IRQ_CLEAR)) ? wbits[7:0] : 8'h00))
                    | {dead_evt_w, pkt_evt_w};
      irq <= |(irq_status & irq_enable);
      // Start requests queue so two contexts starting together both get a fetch
      pending <= (pending & ~((pick_valid ? 4'h1 : 4'h0) << pick)) | start_w;
      issue <= pick_valid;
      issue_ctx <= pick_valid ? pick : issue_ctx;
      issue2 <= issue;
      // Context number travels with the pointer read, a back-to-back pick must not overtake it
      issue_ctx2 <= issue_ctx;
      fetch_start <= issue2;
      fetch_ctx <= issue2 ? issue_ctx2 : fetch_ctx;
      fetch_addr <= issue2 ? ptr_rd_b : fetch_addr;
      ctx_busy <= act_w;
      backout <= backout_w;
      resp_beta <= beta_w;
    end
  end
endmodule

// ==== verif/iso_rx_status_properties.sv ====
`timescale 1ns/10ps
`include "iso_rx_defs.vh"
module iso_rx_status_checker #(
  parameter NCTX = 4
) (
  // Clock and reset
  input wire ref_clk,
  input wire arst_n,
  // Register bus
  input wire [11:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // Receive path and engine
  input wire [NCTX-1:0] pkt_done,
  input wire [NCTX-1:0] pkt_beta,
  input wire [3*NCTX-1:0] pkt_status,
  input wire [NCTX-1:0] dma_read_err,
  input wire fetch_start,
  input wire [1:0] fetch_ctx,
  input wire [NCTX-1:0] ctx_busy,
  input wire [NCTX-1:0] backout,
  input wire [NCTX-1:0] resp_beta
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  AST_WAIT_CAUSE: assert property (!avs_waitrequest |-> $past(avs_read || avs_write, 2))
    else $error("answer without request two cycles before");
  AST_RESERVED_BITS_ZERO: assert property (avs_read && !avs_waitrequest && avs_address == `ISO_RX_CTRL_SET
    |-> (avs_readdata & 32'h7fff_6100) == 32'h0000_0000) else $error("reserved control bits not zero");
  AST_START_FETCH: assert property ($rose(ctx_busy[0]) |-> ##[1:6] (fetch_start && fetch_ctx == 2'h0))
    else $error("no fetch after context start");
  AST_BACKOUT_CAUSE: assert property (backout[1] |-> $past(pkt_done[1], 2) && $past(pkt_status[5:3], 2) != 3'h0)
    else $error("backout without bad packet");
  AST_BACKOUT_BUSY: assert property (backout[1] |-> ctx_busy[1])
    else $error("backout while context idle");
  AST_BETA_RESP: assert property (pkt_done[0] && pkt_beta[0] && ctx_busy[0] |-> ##[1:2] resp_beta[0])
    else $error("beta packet not answered in beta");
  AST_DEAD_IDLE: assert property (dma_read_err[0] && ctx_busy[0] |-> ##2 !ctx_busy[0] [*3])
    else $error("context still busy after fatal error");
  cover property (backout[1]);
  cover property (fetch_start && fetch_ctx == 2'h1);
  cover property (pkt_done[0] && pkt_beta[0]);
endmodule
bind iso_receive_context_status iso_rx_status_checker #(.NCTX(NCTX)) chk_u (.ref_clk(ref_clk), .arst_n(arst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pkt_done(pkt_done), .pkt_beta(pkt_beta), .pkt_status(pkt_status),
  .dma_read_err(dma_read_err), .fetch_start(fetch_start), .fetch_ctx(fetch_ctx), .ctx_busy(ctx_busy),
  .backout(backout), .resp_beta(resp_beta));

// ==== verif/rx_far_side.sv ====
`timescale 1ns/10ps
module rx_far_side (
  // Clock and reset
  input wire ref_clk,
  input wire arst_n,
  // Context state
  input wire [3:0] ctx_busy,
  // Receive path and fetch reports
  output logic [3:0] pkt_done,
  output logic [3:0] pkt_beta,
  output logic [11:0] pkt_speed,
  output logic [11:0] pkt_status,
  output logic [3:0] desc_fetch
);
  logic go = 1'h0;
  logic [1:0] c;
  logic b;
  logic [2:0] sp;
  logic [2:0] st;
  logic [2:0] cnt;
  // Idle lanes toggle so a stale value is never mistaken for a packet
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pkt_done <= 4'h0;
      pkt_beta <= 4'h0;
      pkt_speed <= 12'h000;
      pkt_status <= 12'h000;
      desc_fetch <= 4'h0;
      cnt <= 3'h0;
    end else begin
      cnt <= cnt + 3'h1;
      desc_fetch <= ctx_busy & {4{cnt == 3'h0}};
      pkt_done <= 4'h0;
      pkt_beta <= ~pkt_beta;
      pkt_speed <= ~pkt_speed;
      pkt_status <= ~pkt_status;
      if (go) begin
        go <= 1'h0;
        pkt_done[c] <= 1'h1;
        pkt_beta[c] <= b;
        pkt_speed[3*c+:3] <= sp;
        pkt_status[3*c+:3] <= st;
      end
    end
  end
  task automatic send(input logic [1:0] cc, input logic bb, input logic [2:0] s1, input logic [2:0] s2);
    @(negedge ref_clk);
    c = cc;
    b = bb;
    sp = s1;
    st = s2;
    go = 1'h1;
    while (go) @(posedge ref_clk);
    @(posedge ref_clk);
  endtask
endmodule

// ==== verif/iso_receive_context_status_tb.sv ====
`timescale 1ns/10ps
`include "iso_rx_defs.vh"
module iso_receive_context_status_tb;
  logic ref_clk = 1'h0;
  logic arst_n = 1'h0;
  logic [11:0] avs_address = 12'h000;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, fetch_addr, v;
  logic [31:0] ptr_value = 32'h0000_0000;
  logic avs_waitrequest, irq, fetch_start;
  logic ptr_load = 1'h0;
  logic [1:0] fetch_ctx;
  logic [1:0] ptr_ctx = 2'h0;
  logic [3:0] pkt_done, pkt_beta, desc_fetch, ctx_busy, backout, resp_beta;
  logic [3:0] rd_err = 4'h0;
  logic [3:0] wr_err = 4'h0;
  logic [3:0] unk_err = 4'h0;
  logic [3:0] lst_end = 4'h0;
  logic [11:0] pkt_speed, pkt_status;
  logic [4:0] ppb_evt [5] = '{`EVT_ACK_COMPLETE, `EVT_ACK_DATA_ERROR, `EVT_ACK_DATA_ERROR, `EVT_OVERRUN,
    `EVT_LONG_PACKET};
  int bo_cnt = 0;
  int failures = 0;
  int num_checks = 0;
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (backout[1] === 1'h1) bo_cnt++;
  iso_receive_context_status dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .pkt_done(pkt_done),
    .pkt_beta(pkt_beta), .pkt_speed(pkt_speed), .pkt_status(pkt_status), .desc_fetch(desc_fetch),
    .dma_read_err(rd_err), .dma_write_err(wr_err), .unknown_err(unk_err), .list_end(lst_end), .ptr_load(ptr_load),
    .ptr_ctx(ptr_ctx), .ptr_value(ptr_value), .fetch_start(fetch_start), .fetch_ctx(fetch_ctx),
    .fetch_addr(fetch_addr), .ctx_busy(ctx_busy), .backout(backout), .resp_beta(resp_beta));
  rx_far_side peer_u (.ref_clk(ref_clk), .arst_n(arst_n), .ctx_busy(ctx_busy), .pkt_done(pkt_done),
    .pkt_beta(pkt_beta), .pkt_speed(pkt_speed), .pkt_status(pkt_status), .desc_fetch(desc_fetch));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // Holds the request until waitrequest is seen low, then one idle edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'h0) @(posedge ref_clk);
    v = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge ref_clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_ptr;
    bus(1'h0, `ISO_RX_CTRL_SET, 32'h0000_0000);
    chk(v, 32'h0000_0000);
    for (int c = 0; c < 4; c++) begin
      ptr_load <= 1'h1;
      ptr_ctx <= c[1:0];
      ptr_value <= 32'h0001_0000 + c * 32'h0000_0100;
      @(posedge ref_clk);
      ptr_load <= 1'h0;
      @(posedge ref_clk);
      bus(1'h1, `ISO_RX_PTR + c * 32, 32'hffff_ffff);
      bus(1'h0, `ISO_RX_PTR + c * 32, 32'h0000_0000);
      chk(v, 32'h0001_0000 + c * 32'h0000_0100);
    end
    bus(1'h0, 12'h7fc, 32'h0000_0000);
    chk(v, 32'h0000_0000);
    $display("test_ptr done");
  endtask
  task automatic test_start;
    bus(1'h1, `ISO_RX_CTRL_SET, 32'h0000_8000);
    while (fetch_start !== 1'h1) @(posedge ref_clk);
    chk(fetch_addr, 32'h0001_0000);
    chk(fetch_ctx, 2'h0);
    bus(1'h0, `ISO_RX_CTRL_SET, 32'h0000_0000);
    chk(v & 32'h0000_8400, 32'h0000_8400);
    bus(1'h1, `ISO_RX_CTRL_SET, 32'h0000_1000);
    repeat (12) @(posedge ref_clk);
    bus(1'h0, `ISO_RX_CTRL_CLR, 32'h0000_0000);
    chk(v & 32'h0000_1000, 32'h0000_0000);
    $display("test_start done");
  endtask
  task automatic test_ppb;
    for (int s = 0; s < 5; s++) begin
      peer_u.send(2'h0, s[0], s[2:0] & 3'h3, s[2:0]);
      bus(1'h0, `ISO_RX_CTRL_SET, 32'h0000_0000);
      chk(v & 32'h0000_03ff, {22'h0, s[0], 1'h0, s[1:0] == 2'h0 ? 3'h0 : {1'h0, s[1:0]}, ppb_evt[s]});
      chk(resp_beta[0], s[0]);
    end
    $display("test_ppb done");
  endtask
  task automatic test_fill;
    int n0;
    bus(1'h1, `ISO_RX_CTRL_SET + 12'h020, 32'h8000_0000);
    bus(1'h1, `ISO_RX_CTRL_SET + 12'h020, 32'h0000_8000);
    while (!(fetch_start === 1'h1 && fetch_ctx === 2'h1)) @(posedge ref_clk);
    chk(fetch_addr, 32'h0001_0100);
    peer_u.send(2'h1, 1'h0, 3'h1, `PKT_OK);
    for (int st = 1; st < 4; st++) begin
      n0 = bo_cnt;
      peer_u.send(2'h1, 1'h1, 3'h3, st[2:0]);
      repeat (3) @(posedge ref_clk);
      chk(bo_cnt - n0, 1);
    end
    bus(1'h0, `ISO_RX_CTRL_SET + 12'h020, 32'h0000_0000);
    chk(v & 32'h8000_041f, 32'h8000_0400 | {27'h0, `EVT_ACK_COMPLETE});
    $display("test_fill done");
  endtask
  task automatic test_dead;
    rd_err <= 4'h1;
    @(posedge ref_clk);
    rd_err <= 4'h0;
    repeat (3) @(posedge ref_clk);
    bus(1'h0, `ISO_RX_CTRL_SET, 32'h0000_0000);
    chk(v & 32'h0000_8c1f, 32'h0000_8800 | {27'h0, `EVT_DESCRIPTOR_READ});
    chk(ctx_busy[0], 1'h0);
    chk(irq, 1'h0);
    bus(1'h0, `ISO_RX_IRQ_STATUS, 32'h0000_0000);
    chk(v & 32'h0000_0010, 32'h0000_0010);
    bus(1'h1, `ISO_RX_IRQ_ENABLE, 32'h0000_0010);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'h1);
    bus(1'h1, `ISO_RX_IRQ_CLEAR, 32'h0000_0010);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'h0);
    bus(1'h1, `ISO_RX_CTRL_CLR, 32'h0000_8000);
    bus(1'h0, `ISO_RX_CTRL_SET, 32'h0000_0000);
    chk(v & 32'h0000_8800, 32'h0000_0000);
    $display("test_dead done");
  endtask
  task automatic test_errs;
    wr_err <= 4'h2;
    @(posedge ref_clk);
    wr_err <= 4'h0;
    repeat (3) @(posedge ref_clk);
    bus(1'h0, `ISO_RX_CTRL_SET + 12'h020, 32'h0000_0000);
    chk(v & 32'h0000_0c1f, 32'h0000_0800 | {27'h0, `EVT_DATA_WRITE});
    unk_err <= 4'h2;
    @(posedge ref_clk);
    unk_err <= 4'h0;
    repeat (3) @(posedge ref_clk);
    bus(1'h0, `ISO_RX_CTRL_SET + 12'h020, 32'h0000_0000);
    chk(v & 32'h0000_001f, {27'h0, `EVT_UNKNOWN});
    bus(1'h1, `ISO_RX_CTRL_SET, 32'h0000_8000);
    repeat (6) @(posedge ref_clk);
    chk(ctx_busy[0], 1'h1);
    lst_end <= 4'h1;
    @(posedge ref_clk);
    lst_end <= 4'h0;
    repeat (3) @(posedge ref_clk);
    chk(ctx_busy[0], 1'h0);
    $display("test_errs done");
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'h1;
    @(posedge ref_clk);
    test_ptr();
    test_start();
    test_ppb();
    test_fill();
    test_dead();
    test_errs();
    tally_and_finish();
  end
  // Whole run needs a few hundred cycles; twenty thousand means a hang
  initial begin
    #400000;
    failures++;
    tally_and_finish();
  end
endmodule
